// ---- hw/fwd_ctl_pkg.sv ----
// constants for the bridge forwarding control dword
`default_nettype none
package fwd_ctl_pkg;
  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CTL_DWORD_OFS   = 8'h3C;
  localparam int          LINE_LSB        = 0;
  localparam int          PIN_LSB         = 8;
  localparam int          PAR_RESP_BIT    = 16;
  localparam int          SERR_FWD_BIT    = 17;
  localparam int          ISA_EN_BIT      = 18;
  localparam int          VGA_EN_BIT      = 19;
  localparam int          RSVD_BIT        = 20;
  localparam int          LINE_BE         = 0;
  localparam int          CTL_BE          = 2;
  // ----------------------------------------------------------------------
  // reset and fixed values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  LINE_RST        = 8'h00;
  localparam logic [7:0]  PIN_NONE        = 8'h00;
  localparam logic        CTL_BIT_RST     = 1'b0;
  localparam logic [31:0] RDATA_RST       = 32'h0000_0000;
  localparam logic        SERR_N_IDLE     = 1'b1;
  // ----------------------------------------------------------------------
  // address decode constants
  // ----------------------------------------------------------------------
  localparam logic [31:0] IO_64K_LIMIT    = 32'h0000_FFFF;
  localparam logic [31:0] VGA_MEM_LO      = 32'h000A_0000;
  localparam logic [31:0] VGA_MEM_HI      = 32'h000B_FFFF;
  localparam logic [9:0]  VGA_IO_A_LO     = 10'h3B0;
  localparam logic [9:0]  VGA_IO_A_HI     = 10'h3BB;
  localparam logic [9:0]  VGA_IO_B_LO     = 10'h3C0;
  localparam logic [9:0]  VGA_IO_B_HI     = 10'h3DF;

  typedef struct packed {
    logic [7:0]  irq_line;
    logic        par_resp;
    logic        serr_fwd_en;
    logic        isa_en;
    logic        vga_en;
    logic [31:0] rdata;
    logic        serr_meta;
    logic        serr_sync;
    logic        pri_serr_req;
    logic        fwd_down;
    logic        fwd_up;
  } state_type;
endpackage
`default_nettype wire

// ---- hw/fwd_dec_if.sv ----
// carrier between the control registers and the address decoder
`default_nettype none
interface fwd_dec_if;
  logic        isa_en;
  logic        vga_en;
  logic [31:0] addr;
  logic        is_io;
  logic        is_mem;
  logic [31:0] io_base;
  logic [31:0] io_limit;
  logic        mem_window_hit;
  logic        down_hit;
  logic        up_pass;

  modport ctl (output isa_en, vga_en, addr, is_io, is_mem, io_base,
               io_limit, mem_window_hit, input down_hit, up_pass);
  modport dec (input isa_en, vga_en, addr, is_io, is_mem, io_base,
               io_limit, mem_window_hit, output down_hit, up_pass);
endinterface
`default_nettype wire

// ---- hw/fwd_addr_decode.sv ----
// combinational isa/vga aware forwarding decode
`default_nettype none
module fwd_addr_decode
  import fwd_ctl_pkg::*;
(
  // decode carrier
  fwd_dec_if.dec dec
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // upper 768 bytes of each 1KB block: bits 9:8 not both zero
  function automatic logic isa_alias(input logic [31:0] a);
    isa_alias = (a[9:8] != 2'b00);
  endfunction

  function automatic logic in_range(input logic [31:0] a,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  logic in_win;
  logic low64k;
  logic isa_block;
  logic vga_io;
  logic vga_mem;

  always_comb
  begin
    in_win    = in_range(dec.addr, dec.io_base, dec.io_limit);
    low64k    = (dec.addr <= IO_64K_LIMIT);
    isa_block = dec.isa_en && in_win && low64k
             && isa_alias(dec.addr);
    // vga i/o decoded on ten address bits only, aliases included
    vga_io    = in_range({22'h0, dec.addr[9:0]}, {22'h0, VGA_IO_A_LO},
                         {22'h0, VGA_IO_A_HI})
             || in_range({22'h0, dec.addr[9:0]}, {22'h0, VGA_IO_B_LO},
                         {22'h0, VGA_IO_B_HI});
    vga_mem   = in_range(dec.addr, VGA_MEM_LO, VGA_MEM_HI);
    dec.down_hit = 1'b0;
    dec.up_pass  = 1'b0;
    if (dec.is_io)
    begin
      // vga overrides the window and the isa filter
      dec.down_hit = (dec.vga_en && vga_io)
                  || (in_win && !isa_block);
      dec.up_pass  = !(dec.vga_en && vga_io)
                  && (!in_win
                      || (dec.isa_en && isa_alias(dec.addr)));
    end
    else if (dec.is_mem)
    begin
      dec.down_hit = (dec.vga_en && vga_mem) || dec.mem_window_hit;
      dec.up_pass  = !(dec.vga_en && vga_mem) && !dec.mem_window_hit;
    end
  end

endmodule
`default_nettype wire

// ---- hw/bridge_forwarding_control.sv ----
// configuration dword 3Ch: irq line/pin and low bridge control bits
`default_nettype none
// What this block does
// - low byte is a plain read/write irq line value, nothing uses it
// - bits 15:8 read as no irq pin, writes ignored
// - bit 16 enables secondary parity detection and report, resets 0
// - bit 17 gates secondary system error to primary, resets 0
// - isa bit clear forwards every i/o address inside the window
// - isa bit set blocks window hits below 64KB in alias ranges
// - isa bit set passes secondary alias-range i/o upstream
// - vga bit set forwards vga memory and i/o downstream regardless
// - bit 20 reserved: reads zero, writes ignored, resets zero
module bridge_forwarding_control
  import fwd_ctl_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // configuration access
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output var  logic [31:0] cfg_rdata,
  // secondary error pin and primary request
  input  wire logic        secondary_system_error_n,
  output var  logic        pri_serr_req,
  // parity control to the secondary interface
  output var  logic        sec_parity_check,
  // address query from the transaction engine
  input  wire logic [31:0] q_addr,
  input  wire logic        q_is_io,
  input  wire logic        q_is_mem,
  input  wire logic [31:0] io_base,
  input  wire logic [31:0] io_limit,
  input  wire logic        mem_window_hit,
  output var  logic        fwd_down,
  output var  logic        fwd_up
);

  state_type st_r;
  state_type st_nxt;
  logic      hit_dword;

  fwd_dec_if dif ();

  fwd_addr_decode u_dec (
    .dec (dif.dec)
  );

  assign dif.isa_en         = st_r.isa_en;
  assign dif.vga_en         = st_r.vga_en;
  assign dif.addr           = q_addr;
  assign dif.is_io          = q_is_io;
  assign dif.is_mem         = q_is_mem;
  assign dif.io_base        = io_base;
  assign dif.io_limit       = io_limit;
  assign dif.mem_window_hit = mem_window_hit;

  assign hit_dword = (cfg_addr == CTL_DWORD_OFS);

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    if (cfg_wr && hit_dword)
    begin
      if (cfg_be[LINE_BE])
      begin
        st_nxt.irq_line = cfg_wdata[LINE_LSB +: 8];
      end
      // pin byte and bit 20 have no storage, so writes fall away
      if (cfg_be[CTL_BE])
      begin
        st_nxt.par_resp    = cfg_wdata[PAR_RESP_BIT];
        st_nxt.serr_fwd_en = cfg_wdata[SERR_FWD_BIT];
        st_nxt.isa_en      = cfg_wdata[ISA_EN_BIT];
        st_nxt.vga_en      = cfg_wdata[VGA_EN_BIT];
      end
    end
    // read data held until the next read; other offsets read zero here
    if (cfg_rd)
    begin
      st_nxt.rdata = RDATA_RST;
      if (hit_dword)
      begin
        st_nxt.rdata[LINE_LSB +: 8]  = st_r.irq_line;
        st_nxt.rdata[PIN_LSB +: 8]   = PIN_NONE;
        st_nxt.rdata[PAR_RESP_BIT]   = st_r.par_resp;
        st_nxt.rdata[SERR_FWD_BIT]   = st_r.serr_fwd_en;
        st_nxt.rdata[ISA_EN_BIT]     = st_r.isa_en;
        st_nxt.rdata[VGA_EN_BIT]     = st_r.vga_en;
        st_nxt.rdata[RSVD_BIT]       = 1'b0;
      end
    end
    // pin comes from another bus, two flops before use
    st_nxt.serr_meta    = secondary_system_error_n;
    st_nxt.serr_sync    = st_r.serr_meta;
    st_nxt.pri_serr_req = st_r.serr_fwd_en && !st_r.serr_sync;
    st_nxt.fwd_down     = dif.down_hit;
    st_nxt.fwd_up       = dif.up_pass;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_r.irq_line     <= LINE_RST;
      st_r.par_resp     <= CTL_BIT_RST;
      st_r.serr_fwd_en  <= CTL_BIT_RST;
      st_r.isa_en       <= CTL_BIT_RST;
      st_r.vga_en       <= CTL_BIT_RST;
      st_r.rdata        <= RDATA_RST;
      st_r.serr_meta    <= SERR_N_IDLE;
      st_r.serr_sync    <= SERR_N_IDLE;
      st_r.pri_serr_req <= 1'b0;
      st_r.fwd_down     <= 1'b0;
      st_r.fwd_up       <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign cfg_rdata        = st_r.rdata;
  assign pri_serr_req     = st_r.pri_serr_req;
  assign sec_parity_check = st_r.par_resp;
  assign fwd_down         = st_r.fwd_down;
  assign fwd_up           = st_r.fwd_up;

endmodule
`default_nettype wire

// ---- verif/serr_agent.sv ----
// secondary agent model driving the system error pin
`default_nettype none
module serr_agent (
  // ----
  // bench request and pin, driven high while released
  // ----
  input  wire logic err_req,
  output wire logic secondary_system_error_n
);
  timeunit 1ns;
  timeprecision 1ps;
  assign secondary_system_error_n = err_req ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ---- verif/fwd_ctl_chk.sv ----
// assertions on the forwarding control dword ports
`default_nettype none
module fwd_ctl_chk
  import fwd_ctl_pkg::*;
(
  // ----
  // watched ports
  // ----
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [7:0]  cfg_addr,
  input wire logic [3:0]  cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic        secondary_system_error_n,
  input wire logic        pri_serr_req,
  input wire logic        sec_parity_check,
  input wire logic [31:0] q_addr,
  input wire logic        q_is_io,
  input wire logic        q_is_mem,
  input wire logic [31:0] io_base,
  input wire logic [31:0] io_limit,
  input wire logic        mem_window_hit,
  input wire logic        fwd_down,
  input wire logic        fwd_up
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_pin; cfg_rd |=> cfg_rdata[15:8] == 8'h00; endproperty
  a_pin: assert property (p_pin) else $error("pin byte set");
  property p_rsv; cfg_rd |=> cfg_rdata[31:20] == 12'h000; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  property p_par; cfg_wr && cfg_addr == CTL_DWORD_OFS && cfg_be[2]
    |=> sec_parity_check == $past(cfg_wdata[16]); endproperty
  a_par: assert property (p_par) else $error("parity bit");
  property p_hold; !cfg_rd |=> $stable(cfg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  // forwarding needs the pin low three edges earlier
  property p_serr; pri_serr_req |-> !$past(secondary_system_error_n, 3);
  endproperty
  a_serr: assert property (p_serr) else $error("serr fwd");
  property p_win; q_is_io && !q_is_mem && q_addr[9:8] == 2'b00 &&
    q_addr >= io_base && q_addr <= io_limit |=> fwd_down && !fwd_up;
  endproperty
  a_win: assert property (p_win) else $error("window io");
  property p_out; q_is_io && !q_is_mem && q_addr[9:8] == 2'b00 &&
    q_addr > io_limit |=> fwd_up && !fwd_down; endproperty
  a_out: assert property (p_out) else $error("outside io");
  property p_mem; q_is_mem && !q_is_io && !mem_window_hit &&
    q_addr > VGA_MEM_HI |=> !fwd_down && fwd_up; endproperty
  a_mem: assert property (p_mem) else $error("mem fwd");
endmodule
bind bridge_forwarding_control fwd_ctl_chk fwd_ctl_chk_i (.*);
`default_nettype wire

// ---- verif/tb.sv ----
// bench for the forwarding control dword
`default_nettype none
module tb
  import fwd_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0;
  logic q_is_io = 1'b0, q_is_mem = 1'b0, mem_window_hit = 1'b0;
  logic err_req = 1'b0;
  logic [7:0] cfg_addr = 8'h3C;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0, q_addr = 32'h0, cfg_rdata;
  logic [31:0] io_base = 32'h0, io_limit = 32'h0001_FFFF;
  wire logic secondary_system_error_n, pri_serr_req, sec_parity_check;
  wire logic fwd_down, fwd_up;
  int fails = 0, check_count = 0;
  bridge_forwarding_control bridge_forwarding_control_i (.*);
  serr_agent serr_agent_i (.*);
  always #5ns sys_clk = ~sys_clk;
  // ----
  // access tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] b,
                    input logic [31:0] d);
    @(posedge sys_clk);
    {cfg_wr, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, a, b, d};
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    {cfg_rd, cfg_addr} <= {1'b1, a};
    @(posedge sys_clk);
    cfg_rd <= 1'b0;
    #1 chk(cfg_rdata, exp);
  endtask
  // decode answers one edge after the query is presented
  task automatic qry(input logic [31:0] a, input logic io,
                     input logic [1:0] exp);
    @(posedge sys_clk);
    {q_addr, q_is_io, q_is_mem} <= {a, io, !io};
    @(posedge sys_clk);
    #1 chk({30'h0, fwd_down, fwd_up}, {30'h0, exp});
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h3C, 32'h0);
    wr(8'h3C, 4'hF, 32'hFFFF_FFFF);
    rd(8'h3C, 32'h000F_00FF);
    chk({31'h0, sec_parity_check}, 32'h1);
    wr(8'h3C, 4'h3, 32'h0000_AB12);
    rd(8'h3C, 32'h000F_0012);
    wr(8'h40, 4'hF, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0);
    rd(8'h3C, 32'h000F_0012);
    $display("test registers done");
    wr(8'h3C, 4'h4, 32'h0002_0000);
    @(posedge sys_clk) err_req <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 chk({31'h0, pri_serr_req}, 32'h1);
    wr(8'h3C, 4'h4, 32'h0);
    repeat (2) @(posedge sys_clk);
    #1 chk({31'h0, pri_serr_req}, 32'h0);
    @(posedge sys_clk) err_req <= 1'b0;
    $display("test serr done");
    wr(8'h3C, 4'h4, 32'h0004_0000);
    qry(32'h0000_0100, 1'b1, 2'b01);
    qry(32'h0000_0300, 1'b1, 2'b01);
    qry(32'h0000_00C0, 1'b1, 2'b10);
    qry(32'h0001_0100, 1'b1, 2'b11);
    wr(8'h3C, 4'h4, 32'h0);
    qry(32'h0000_0100, 1'b1, 2'b10);
    qry(32'h0002_03C0, 1'b1, 2'b01);
    qry(32'h0002_0000, 1'b1, 2'b01);
    qry(32'h000A_0000, 1'b0, 2'b01);
    wr(8'h3C, 4'h4, 32'h0008_0000);
    qry(32'h0002_03C0, 1'b1, 2'b10);
    qry(32'h0002_07B4, 1'b1, 2'b10);
    qry(32'h0002_03BC, 1'b1, 2'b01);
    qry(32'h000B_FFFF, 1'b0, 2'b10);
    qry(32'h000C_0000, 1'b0, 2'b01);
    @(posedge sys_clk) mem_window_hit <= 1'b1;
    qry(32'h000C_0000, 1'b0, 2'b10);
    $display("test decode done");
    @(posedge sys_clk) rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h3C, 32'h0);
    $display("test reset done");
    give_verdict;
  end
  initial
  begin
    repeat (2000) @(posedge sys_clk);
    fails++;
    give_verdict;
  end
endmodule
`default_nettype wire
